// ==== hw/pts_lane_if.sv ====
// Purpose: bundle between the serializer control and its shift lanes
// Assumes: all signals on the bit clock
// Notes: control drives load and word, lanes drive serial
`timescale 1ns/100ps
`include "pts_regs.svh"

interface pts_lane_if;
   import pts_pkg::*;
   logic load;
   logic run;
   pts_word_t word;
   logic [`PTS_LANES-1:0] serial;
   modport ctrl (output load, output run, output word, input serial);
   modport lanes (input load, input run, input word, output serial);
endinterface

// ==== hw/pts_pkg.sv ====
// Purpose: types shared by the link transmitter files
// Assumes: pts_regs.svh gives the widths
// Notes: types only
`include "pts_regs.svh"

package pts_pkg;
   typedef logic [`PTS_WORD_BITS-1:0] pts_word_t;
   typedef logic [2:0] pts_slot_t;
   typedef logic [3:0] pts_lock_cnt_t;
   // gray coded along off -> wait -> run
   typedef enum logic [1:0] {
      PTS_OFF = 2'b00,
      PTS_WAIT = 2'b01,
      PTS_RUN = 2'b11
   } pts_link_state_t;
endpackage

// ==== hw/pts_regs.svh ====
// Purpose: constants of the 21-to-3 parallel-to-serial link transmitter
// Assumes: included by bare name wherever a constant is needed
// Notes: definitions only
`ifndef PTS_REGS_SVH
`define PTS_REGS_SVH

// word and lane geometry
`define PTS_WORD_BITS 21
`define PTS_LANES 3
`define PTS_LANE_BITS 7
`define PTS_DRIVERS 4

// serial slot numbers
`define PTS_SLOT_FIRST 3'h0
`define PTS_SLOT_LAST 3'h6
`define PTS_FWD_HIGH_SLOTS 3'h4

// lock range of the bit clock source, in MHz, and tracking limits
`define PTS_LOCK_MIN_MHZ 31
`define PTS_LOCK_MAX_MHZ 75
`define PTS_SSC_SPREAD_PCT 3
`define PTS_SSC_MOD_KHZ 50

// aligned words counted before the next aligned word sets lock
`define PTS_LOCK_WORDS 4'h8

`endif

// ==== hw/pts_serializer.sv ====
// Purpose: top of the 21-to-3 parallel-to-serial display link transmitter
// Assumes: mclk is the pixel input clock; bit_clk comes from a pll locked at 7x mclk
// Notes: shutdown_clear_n clears every register and turns all drivers off
`timescale 1ns/100ps
`include "pts_regs.svh"

// Behaviour
// - Three 7-bit shift registers are loaded in parallel and shifted out, one per data lane.
// - Each pixel period carries 21 bits over three data lanes plus a separate forwarded clock lane.
// - All parallel bits are captured on the falling pixel clock edge, where the controller holds them stable.
// - A bit clock locked to the pixel clock shifts out seven bits per lane in each pixel period.
// - The forwarded clock runs at the pixel frequency and is phase-locked to it.
// - While shutdown is low the clocking stops and all four drivers are turned off.
// - Shutdown low forces every register, load and shift ones included, to zero.
// - The bit clock source locks for pixel clocks from 31 MHz to 75 MHz, which the controller respects.
// - The bit clock source tracks a 3% centre spread at 50 kHz without losing data.
// - Data passes unchanged with no configuration, shutdown being the only control.
// - Serial position n starts n sevenths of a period after the forwarded clock rises, position 0 on it.
module pts_serializer
   import pts_pkg::*;
(
   input wire logic mclk, // pixel input clock
   input wire logic rst_n, // system reset, active low
   input wire logic bit_clk, // serial bit clock, 7x mclk
   input wire logic shutdown_clear_n, // shutdown and clear pin, active low
   input wire logic [`PTS_WORD_BITS-1:0] parallel_pixel_bits, // pixel data
   output logic [`PTS_LANES-1:0] serial_data, // data lanes
   output logic forwarded_clock_out, // forwarded clock lane
   output logic [`PTS_DRIVERS-1:0] lane_drive_en, // driver enables, high drives
   output logic link_locked // words arrive every seventh bit
);
   // ---------------- pixel clock side ----------------
   logic pix_rst_a;
   logic pix_rst_n;
   logic pix_run_a;
   logic pix_run;
   pts_word_t capture;
   pts_word_t hold;
   logic word_toggle;
   logic capt_valid;

   // ---------------- bit clock side ----------------
   logic bit_rst_a;
   logic bit_rst_n;
   logic tog_s1;
   logic tog_s2;
   logic tog_seen;
   pts_word_t staging;
   logic staged;
   pts_link_state_t state;
   pts_link_state_t next_state;
   pts_slot_t slot;
   pts_slot_t next_slot;
   logic fwd;
   logic [`PTS_DRIVERS-1:0] drv_en;
   pts_lock_cnt_t lock_cnt;
   logic locked;
   logic on_time;
   logic slot_wrap;
   logic new_word;
   logic do_load;

   pts_lane_if lif ();

   // shutdown joins the system reset; either clears the whole block
   wire clear_n = rst_n & shutdown_clear_n;

   // reset release is synchronised in each domain, assertion stays asynchronous
   always_ff @(negedge mclk or negedge clear_n) begin
      if (!clear_n) begin
         pix_rst_a <= 1'b0;
         pix_rst_n <= 1'b0;
      end else begin
         pix_rst_a <= 1'b1;
         pix_rst_n <= pix_rst_a;
      end
   end

   always_ff @(posedge bit_clk or negedge clear_n) begin
      if (!clear_n) begin
         bit_rst_a <= 1'b0;
         bit_rst_n <= 1'b0;
      end else begin
         bit_rst_a <= 1'b1;
         bit_rst_n <= bit_rst_a;
      end
   end

   // second stage run flag; holds capt_valid low, and so hold idle, until reset has fully left
   always_ff @(negedge mclk or negedge pix_rst_n) begin
      if (!pix_rst_n) begin
         pix_run_a <= 1'b0;
         pix_run <= 1'b0;
      end else begin
         pix_run_a <= 1'b1;
         pix_run <= pix_run_a;
      end
   end

   // falling edge capture of all 21 bits, then a second stage that the far domain reads
   always_ff @(negedge mclk or negedge pix_rst_n) begin
      if (!pix_rst_n) begin
         capture <= '0;
         capt_valid <= 1'b0;
      end else begin
         capture <= parallel_pixel_bits;
         capt_valid <= pix_run;
      end
   end

   // hold changes once per pixel period, so it is quiet for a full period after each toggle
   always_ff @(negedge mclk or negedge pix_rst_n) begin
      if (!pix_rst_n) begin
         hold <= '0;
         word_toggle <= 1'b0;
      end else if (capt_valid) begin
         hold <= capture;
         word_toggle <= ~word_toggle;
      end
   end

   // toggle crossing: two flops, the third keeps the old value for the edge test
   always_ff @(posedge bit_clk or negedge bit_rst_n) begin
      if (!bit_rst_n) begin
         tog_s1 <= 1'b0;
         tog_s2 <= 1'b0;
         tog_seen <= 1'b0;
      end else begin
         tog_s1 <= word_toggle;
         tog_s2 <= tog_s1;
         tog_seen <= tog_s2;
      end
   end

   // a fresh word is announced; hold has settled for several bit clocks by now
   assign new_word = tog_s2 ^ tog_seen;

   // staging keeps the latest word until the lanes take it at the slot boundary
   always_ff @(posedge bit_clk or negedge bit_rst_n) begin
      if (!bit_rst_n) begin
         staging <= '0;
         staged <= 1'b0;
      end else if (new_word) begin
         staging <= hold;
         staged <= 1'b1;
      end else if (do_load) begin
         staged <= 1'b0;
      end
   end

   // slot decode and the load point of the shift lanes
   assign slot_wrap = (slot == `PTS_SLOT_LAST);
   assign do_load = (state == PTS_WAIT && staged) || (state == PTS_RUN && slot_wrap);
   assign on_time = staged || new_word;

   // link state: off under clear, wait for the first word, then run
   always_comb begin
      next_state = state;
      unique case (state)
         PTS_OFF: next_state = PTS_WAIT;
         PTS_WAIT: if (staged) next_state = PTS_RUN;
         PTS_RUN: next_state = PTS_RUN;
         default: next_state = PTS_OFF;
      endcase
   end

   // slot counter wraps every seven bit clocks, so one word per pixel period
   always_comb begin
      if (do_load) begin
         next_slot = `PTS_SLOT_FIRST;
      end else if (state == PTS_RUN) begin
         next_slot = slot + 3'h1;
      end else begin
         next_slot = slot;
      end
   end

   // the clock is stopped in shutdown simply by holding state in reset
   always_ff @(posedge bit_clk or negedge bit_rst_n) begin
      if (!bit_rst_n) begin
         state <= PTS_OFF;
         slot <= `PTS_SLOT_FIRST;
      end else begin
         state <= next_state;
         slot <= next_slot;
      end
   end

   // forwarded clock: high for slots 0 to 3, low for 4 to 6, rising with position 0
   always_ff @(posedge bit_clk or negedge bit_rst_n) begin
      if (!bit_rst_n) begin
         fwd <= 1'b0;
      end else if (state == PTS_OFF) begin
         fwd <= 1'b0;
      end else if (state == PTS_WAIT && !staged) begin
         fwd <= 1'b0;
      end else begin
         fwd <= (next_slot < `PTS_FWD_HIGH_SLOTS);
      end
   end

   // drivers come on once the first word is on the lanes; off whenever cleared
   always_ff @(posedge bit_clk or negedge bit_rst_n) begin
      if (!bit_rst_n) begin
         drv_en <= '0;
      end else begin
         drv_en <= {`PTS_DRIVERS{next_state == PTS_RUN}};
      end
   end

   // lock watch: a word must be pending at each wrap, else the bit clock is off-ratio
   // the bit clock pll is external; this only reports whether it tracks mclk
   always_ff @(posedge bit_clk or negedge bit_rst_n) begin
      if (!bit_rst_n) begin
         lock_cnt <= 4'h0;
         locked <= 1'b0;
      end else if (state == PTS_RUN && slot_wrap) begin
         if (!on_time) begin
            lock_cnt <= 4'h0;
            locked <= 1'b0;
         end else if (lock_cnt != `PTS_LOCK_WORDS) begin
            lock_cnt <= lock_cnt + 4'h1;
         end else begin
            locked <= 1'b1;
         end
      end
   end

   // lane bundle; run low keeps the shift registers at zero
   assign lif.load = do_load;
   assign lif.run = (state != PTS_OFF);
   assign lif.word = staging;

   pts_shift_lanes u_lanes (
      .bit_clk(bit_clk),
      .bit_rst_n(bit_rst_n),
      .lif(lif)
   );

   // outputs straight from flops
   assign serial_data = lif.serial;
   assign forwarded_clock_out = fwd;
   assign lane_drive_en = drv_en;
   assign link_locked = locked;
endmodule

// ==== hw/pts_shift_lanes.sv ====
// Purpose: three 7-bit parallel-load serial-out shift registers
// Assumes: bit clock runs seven times the pixel rate
// Notes: serial outputs come straight from flops
`timescale 1ns/100ps
`include "pts_regs.svh"

module pts_shift_lanes
   import pts_pkg::*;
(
   input wire logic bit_clk, // serial bit clock
   input wire logic bit_rst_n, // bit domain reset, active low
   pts_lane_if.lanes lif // load, word and serial bits
);
   logic [`PTS_LANE_BITS-2:0] sr [`PTS_LANES];
   logic [`PTS_LANES-1:0] ser;

   assign lif.serial = ser;

   // one shift register per lane, lowest bit leaves first
   for (genvar k = 0; k < `PTS_LANES; k++) begin : g_lane
      wire [`PTS_LANE_BITS-1:0] slice = lif.word[k*`PTS_LANE_BITS +: `PTS_LANE_BITS];
      always_ff @(posedge bit_clk or negedge bit_rst_n) begin
         if (!bit_rst_n) begin
            sr[k] <= 6'h00;
            ser[k] <= 1'b0;
         end else if (!lif.run) begin
            sr[k] <= 6'h00;
            ser[k] <= 1'b0;
         end else if (lif.load) begin
            sr[k] <= slice[`PTS_LANE_BITS-1:1];
            ser[k] <= slice[0];
         end else begin
            ser[k] <= sr[k][0];
            sr[k] <= {1'b0, sr[k][`PTS_LANE_BITS-2:1]};
         end
      end
   end
endmodule

// ==== test/pts_rx_model.sv ====
// Purpose: deserialising receiver at the far end of the link
// Assumes: lines sampled mid-bit on the falling bit clock
// Notes: words are read by the bench from the queue
`timescale 1ns/100ps
`include "pts_regs.svh"

module pts_rx_model
   import pts_pkg::*;
(
   input wire logic bit_clk, // bit clock
   input wire logic [`PTS_LANES-1:0] serial_data, // data lanes
   input wire logic forwarded_clock_out, // clock lane
   input wire logic [`PTS_DRIVERS-1:0] lane_drive_en // driver enables
);
   pts_word_t words[$]; // received words, oldest first
   logic [6:0] sh [3];
   logic fwd_q = 1'b0;
   int slot = 7;

   // falling edge sampling avoids racing the launching edge
   always @(negedge bit_clk) begin
      if (!lane_drive_en[3]) begin
         slot = 7;
      end else if (forwarded_clock_out && !fwd_q) begin
         slot = 0;
      end else if (slot < 7) begin
         slot = slot + 1;
      end
      for (int k = 0; k < 3; k++) begin
         sh[k] = {serial_data[k], sh[k][6:1]};
      end
      if (slot == 6) begin
         words.push_back({sh[2], sh[1], sh[0]});
      end
      fwd_q = forwarded_clock_out;
   end
endmodule

// ==== test/pts_serializer_sva.sv ====
// Purpose: port checks of the link transmitter
// Assumes: bit_clk is seven times mclk
// Notes: shutdown checks keep only rst_n as disable
`timescale 1ns/100ps
`include "pts_regs.svh"

module pts_serializer_sva (
   input wire logic mclk, // pixel clock
   input wire logic rst_n, // reset, active low
   input wire logic bit_clk, // bit clock
   input wire logic shutdown_clear_n, // shutdown, active low
   input wire logic [`PTS_WORD_BITS-1:0] parallel_pixel_bits, // pixel data
   input wire logic [`PTS_LANES-1:0] serial_data, // data lanes
   input wire logic forwarded_clock_out, // clock lane
   input wire logic [`PTS_DRIVERS-1:0] lane_drive_en, // driver enables
   input wire logic link_locked // lock flag
);
   // all checks on the bit clock; shutdown clears like reset
   default clocking @(posedge bit_clk); endclocking
   default disable iff (!rst_n || !shutdown_clear_n);

   off_drivers_a: assert property (disable iff (!rst_n) !shutdown_clear_n |-> lane_drive_en == 4'h0)
      else $error("drivers on in shutdown");
   off_clear_a: assert property (disable iff (!rst_n) !shutdown_clear_n |-> serial_data == 3'h0 && !link_locked)
      else $error("outputs not cleared in shutdown");
   wake_quiet_a: assert property (disable iff (!rst_n) $rose(shutdown_clear_n) |-> (lane_drive_en == 4'h0) [*3])
      else $error("drivers on right after wake");
   fwd_shape_a: assert property ($rose(forwarded_clock_out) |->
      forwarded_clock_out [*4] ##1 !forwarded_clock_out [*3] ##1 forwarded_clock_out)
      else $error("clock lane not four high three low");
   drv_equal_a: assert property (lane_drive_en == 4'h0 || lane_drive_en == 4'hf)
      else $error("driver enables differ");
   start_slot_a: assert property ($rose(lane_drive_en[3]) |-> $rose(forwarded_clock_out))
      else $error("first frame not on clock rise");
   lock_frames_a: assert property (link_locked |-> ##[0:6] $rose(forwarded_clock_out))
      else $error("locked without seven slot frames");
   lock_drv_a: assert property ($rose(link_locked) |-> lane_drive_en == 4'hf)
      else $error("locked with lanes off");

   cover property ($rose(link_locked));
   cover property (disable iff (!rst_n) $fell(shutdown_clear_n));
   cover property ($rose(forwarded_clock_out));
endmodule

bind pts_serializer pts_serializer_sva pts_serializer_sva_inst (.mclk(mclk), .rst_n(rst_n), .bit_clk(bit_clk),
   .shutdown_clear_n(shutdown_clear_n), .parallel_pixel_bits(parallel_pixel_bits), .serial_data(serial_data),
   .forwarded_clock_out(forwarded_clock_out), .lane_drive_en(lane_drive_en), .link_locked(link_locked));

// ==== test/pts_serializer_tb.sv ====
// Purpose: self-checking bench of the link transmitter
// Assumes: bit clock made locked at seven times mclk
// Notes: words are compared at the receiver model
`timescale 1ns/100ps
`include "pts_regs.svh"

module pts_serializer_tb;
   import pts_pkg::*;
   logic mclk = 1'b0;
   logic bit_clk = 1'b0;
   logic rst_n = 1'b0;
   logic shutdown_clear_n = 1'b1;
   pts_word_t parallel_pixel_bits = '0;
   logic [`PTS_LANES-1:0] serial_data;
   logic forwarded_clock_out;
   logic [`PTS_DRIVERS-1:0] lane_drive_en;
   logic link_locked;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;

   pts_serializer pts_serializer_inst (.mclk(mclk), .rst_n(rst_n), .bit_clk(bit_clk),
      .shutdown_clear_n(shutdown_clear_n), .parallel_pixel_bits(parallel_pixel_bits), .serial_data(serial_data),
      .forwarded_clock_out(forwarded_clock_out), .lane_drive_en(lane_drive_en), .link_locked(link_locked));
   pts_rx_model pts_rx_model_inst (.bit_clk(bit_clk), .serial_data(serial_data),
      .forwarded_clock_out(forwarded_clock_out), .lane_drive_en(lane_drive_en));

   // pixel clock, 40 ns
   initial begin
      forever #20 mclk = ~mclk;
   end
   // six 5.7 ns bits and one 5.8 ns bit fill 40 ns exactly, so no drift
   initial begin
      #1.3;
      forever begin
         for (int i = 0; i < 14; i++) begin
            bit_clk = ~bit_clk;
            #((i % 2 == 1 && i != 13) ? 2.8 : 2.9);
         end
      end
   end
   // hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // one word per period, stable across the falling edge
   task automatic send(input pts_word_t w);
      @(posedge mclk);
      #1 parallel_pixel_bits = w;
   endtask

   // walking bit over a background: every bit position must land in its lane slot
   task automatic stream_test(input pts_word_t bg);
      int j;
      j = 0;
      send(~bg);
      pts_rx_model_inst.words.delete();
      for (int i = 0; i < 21; i++) send(bg ^ (21'h1 << i));
      repeat (8) send(~bg);
      while (j < pts_rx_model_inst.words.size() && pts_rx_model_inst.words[j] !== (bg ^ 21'h1)) j++;
      for (int i = 0; i < 21; i++) begin
         check("rx word", pts_rx_model_inst.words[j + i], bg ^ (21'h1 << i));
      end
      check("locked", link_locked, 32'h1);
   endtask

   // five clock lane periods must span five pixel periods
   task automatic period_test();
      real t0;
      @(posedge forwarded_clock_out);
      t0 = $realtime;
      repeat (5) @(posedge forwarded_clock_out);
      check("fwd span", int'(($realtime - t0) * 10.0), 32'h7d0);
   endtask

   // shutdown mid-stream clears all, then the link restarts
   task automatic shutdown_test();
      @(posedge mclk);
      #1 shutdown_clear_n = 1'b0;
      repeat (2) @(posedge mclk);
      #2 check("drive en", lane_drive_en, 32'h0);
      check("outputs", {serial_data, forwarded_clock_out, link_locked}, 32'h0);
      @(posedge mclk);
      #1 shutdown_clear_n = 1'b1;
      repeat (2) @(posedge mclk);
      #2 check("wake", lane_drive_en, 32'h0);
      stream_test(21'h0f0f0f);
   endtask

   initial begin
      repeat (20) @(posedge mclk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge mclk);
      stream_test(21'h000000);
      stream_test(21'h1fffff);
      period_test();
      shutdown_test();
      tally_and_finish();
   end
endmodule
